//--- serial_port_consts.svh
// Constants for the dual serial port: timing, rate codes, entry codes and reset values.
// Assumes a 100 MHz board clock; included by the package and the design modules.
//
// How it works
// - Two channels, each configured on its own.
// - Eight rates chosen by five-digit code.
// - Seven or eight data bits per character.
// - Parity none, even or odd, every character.
// - One or two stop bits per character.
// - Handshake paces sending by RTS and CTS.
// - Confirm checks entries, applies only if plausible.
// - Bad entry flags rejection, needs new entry.
// - String sync forces channel one settings.
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH

`define CLK_PERIOD_NS 10
`define BAUD_MAX 19200
`define DIV_W 20

`define RATE_CODE_19200 20'h19200
`define RATE_CODE_9600 20'h09600
`define RATE_CODE_4800 20'h04800
`define RATE_CODE_2400 20'h02400
`define RATE_CODE_1200 20'h01200
`define RATE_CODE_600 20'h00600
`define RATE_CODE_300 20'h00300
`define RATE_CODE_150 20'h00150

`define WIDTH_KEY_8 4'h8
`define WIDTH_KEY_7 4'h7
`define STOP_KEY_1 4'h1
`define STOP_KEY_2 4'h2

// Rate select is the power of two that divides the fastest rate.
`define RESET_RATE_SEL 3'h1
`define SYNC_RATE_SEL 3'h1

`endif

//--- serial_port_pkg.sv
// Types shared by the dual serial port modules.
// Assumes serial_port_consts.svh is on the include path.
package serial_port_pkg;
  `include "serial_port_consts.svh"

  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_EVEN = 2'b01,
    PAR_ODD = 2'b10,
    PAR_BAD = 2'b11
  } parity_t;

  // Settings that steer one transmitter.
  typedef struct packed {
    logic [2:0] rateSel;
    logic sevenBit;
    parity_t parity;
    logic twoStop;
    logic flowCtl;
  } chan_cfg_t;

  // Raw keypad entry for one channel, before the plausibility check.
  typedef struct packed {
    logic [19:0] rateDigits;
    logic [3:0] widthDigit;
    parity_t parityKey;
    logic [3:0] stopDigit;
    logic flow_control_select;
  } entry_t;

  typedef struct packed {
    logic ok;
    chan_cfg_t cfg;
  } check_t;
endpackage

//--- serial_tx_channel.sv
// One asynchronous transmitter with optional RTS/CTS pacing.
// Assumes ctsOk is already synchronised and cfg is a same-clock register.
`include "serial_port_consts.svh"
module serial_tx_channel #(
  parameter logic [`DIV_W-1:0] BitBase = 20'd5208
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Settings and pacing
  input serial_port_pkg::chan_cfg_t cfg,
  input wire logic ctsOk,
  // Character stream
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady,
  // Line
  output logic txd,
  output logic rts
);
  import serial_port_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_PARITY = 3'b011,
    ST_STOP = 3'b100
  } tx_state_t;

  tx_state_t state, next_state;
  chan_cfg_t cfgLat, next_cfgLat;
  logic [7:0] shiftReg, next_shiftReg;
  logic [2:0] bitIdx, next_bitIdx;
  logic [`DIV_W-1:0] divCnt, next_divCnt;
  logic [3:0] bitCnt, next_bitCnt;
  logic parBit, next_parBit, stopLeft, next_stopLeft, next_txd, next_rts, clearToSend;

  function automatic logic [`DIV_W-1:0] bitPeriod(input logic [2:0] sel);
    bitPeriod = `DIV_W'(BitBase << sel) - `DIV_W'(1);
  endfunction

  assign clearToSend = !cfg.flowCtl || ctsOk;
  assign txReady = (state == ST_IDLE) && clearToSend;

  always_comb begin
    next_state = state;
    next_cfgLat = cfgLat;
    next_shiftReg = shiftReg;
    next_bitIdx = bitIdx;
    next_divCnt = divCnt;
    next_bitCnt = bitCnt;
    next_parBit = parBit;
    next_stopLeft = stopLeft;
    next_txd = txd;
    next_rts = cfg.flowCtl ? (txValid || state != ST_IDLE) : 1'b1;
    if (state == ST_IDLE) begin
      next_txd = 1'b1;
      if (txValid && clearToSend) begin
        next_cfgLat = cfg;
        next_shiftReg = txData;
        next_parBit = ^(cfg.sevenBit ? {1'b0, txData[6:0]} : txData) ^ (cfg.parity == PAR_ODD);
        next_divCnt = bitPeriod(cfg.rateSel);
        next_bitCnt = 4'h1;
        next_state = ST_START;
        next_txd = 1'b0;
      end
    end else if (divCnt != '0) begin
      next_divCnt = divCnt - `DIV_W'(1);
    end else begin
      next_divCnt = bitPeriod(cfgLat.rateSel);
      next_bitCnt = bitCnt + 4'h1;
      case (state)
        ST_START: begin
          next_state = ST_DATA;
          next_bitIdx = 3'h0;
          next_txd = shiftReg[0];
        end
        ST_DATA: begin
          if (bitIdx == (cfgLat.sevenBit ? 3'h6 : 3'h7)) begin
            if (cfgLat.parity != PAR_NONE) begin
              next_state = ST_PARITY;
              next_txd = parBit;
            end else begin
              next_state = ST_STOP;
              next_txd = 1'b1;
              next_stopLeft = cfgLat.twoStop;
            end
          end else begin
            next_bitIdx = bitIdx + 3'h1;
            next_shiftReg = {1'b0, shiftReg[7:1]};
            next_txd = shiftReg[1];
          end
        end
        ST_PARITY: begin
          next_state = ST_STOP;
          next_txd = 1'b1;
          next_stopLeft = cfgLat.twoStop;
        end
        ST_STOP: begin
          if (stopLeft) begin
            next_stopLeft = 1'b0;
          end else begin
            next_state = ST_IDLE;
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_txd = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cfgLat <= '0;
      shiftReg <= 8'h00;
      bitIdx <= 3'h0;
      divCnt <= '0;
      bitCnt <= 4'h0;
      parBit <= 1'b0;
      stopLeft <= 1'b0;
      txd <= 1'b1;
      rts <= 1'b0;
    end else begin
      state <= next_state;
      cfgLat <= next_cfgLat;
      shiftReg <= next_shiftReg;
      bitIdx <= next_bitIdx;
      divCnt <= next_divCnt;
      bitCnt <= next_bitCnt;
      parBit <= next_parBit;
      stopLeft <= next_stopLeft;
      txd <= next_txd;
      rts <= next_rts;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the framing and on CTS pacing.
  a_start_low: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_START |-> !txd) else $error("start bit not low");
  a_stop_high: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_STOP |-> txd) else $error("stop bit not high");
  a_frame_length: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_STOP && divCnt == '0 && !stopLeft) |->
    bitCnt == 4'(4'h1 + (cfgLat.sevenBit ? 4'h7 : 4'h8) + (cfgLat.parity != PAR_NONE)
    + cfgLat.twoStop + 4'h1)) else $error("frame has wrong bit count");
  a_parity_value: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_DATA && next_state == ST_PARITY) |=> txd == $past(parBit))
    else $error("parity bit wrong");
  a_cts_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_IDLE && next_state == ST_START && cfg.flowCtl) |-> ctsOk)
    else $error("start without clear to send");
  a_cfg_held: assert property (@(posedge clk) disable iff (!rst_n)
    (state != ST_IDLE && $past(state) != ST_IDLE) |-> $stable(cfgLat))
    else $error("settings changed mid character");
  c_parity_frame: cover property (@(posedge clk) disable iff (!rst_n)
    state == ST_PARITY);
  c_two_stop: cover property (@(posedge clk) disable iff (!rst_n)
    state == ST_STOP && stopLeft);
endmodule

//--- configurable_dual_serial_port.sv
// Two independent serial transmitters with keypad-entered settings.
// Assumes entry, confirm_key, syncFromString and the data streams are on ref_clk;
// cts arrives from pins and is synchronised here.
`include "serial_port_consts.svh"
module configurable_dual_serial_port #(
  parameter int unsigned BaseBitCycles = 1000000000 / (`CLK_PERIOD_NS * `BAUD_MAX)
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Keypad entries
  input serial_port_pkg::entry_t [1:0] entry,
  input wire logic confirm_key,
  input wire logic syncFromString,
  // Character streams
  input wire logic [1:0][7:0] txData,
  input wire logic [1:0] txValid,
  output logic [1:0] txReady,
  // Lines
  output logic [1:0] txd,
  output logic [1:0] rts,
  input wire logic [1:0] cts,
  // Status
  output logic inputRejected,
  output serial_port_pkg::chan_cfg_t [1:0] activeCfg
);
  import serial_port_pkg::*;

  localparam chan_cfg_t ResetCfg = '{rateSel: `RESET_RATE_SEL, sevenBit: 1'b0,
    parity: PAR_NONE, twoStop: 1'b0, flowCtl: 1'b0};
  localparam chan_cfg_t SyncCfg = '{rateSel: `SYNC_RATE_SEL, sevenBit: 1'b0,
    parity: PAR_NONE, twoStop: 1'b0, flowCtl: 1'b0};

  logic [1:0] rstPipe;
  logic rst_n;
  logic [1:0] ctsMeta, ctsOk;
  check_t [1:0] chk;
  chan_cfg_t [1:0] effCfg, next_activeCfg;
  logic next_inputRejected, allOk;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rst_n = rstPipe[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Plausibility check of one entry.
  function automatic check_t checkEntry(input entry_t e);
    check_t r;
    r.ok = 1'b1;
    r.cfg = ResetCfg;
    case (e.rateDigits)
      `RATE_CODE_19200: r.cfg.rateSel = 3'h0;
      `RATE_CODE_9600: r.cfg.rateSel = 3'h1;
      `RATE_CODE_4800: r.cfg.rateSel = 3'h2;
      `RATE_CODE_2400: r.cfg.rateSel = 3'h3;
      `RATE_CODE_1200: r.cfg.rateSel = 3'h4;
      `RATE_CODE_600: r.cfg.rateSel = 3'h5;
      `RATE_CODE_300: r.cfg.rateSel = 3'h6;
      `RATE_CODE_150: r.cfg.rateSel = 3'h7;
      default: r.ok = 1'b0;
    endcase
    case (e.widthDigit)
      `WIDTH_KEY_8: r.cfg.sevenBit = 1'b0;
      `WIDTH_KEY_7: r.cfg.sevenBit = 1'b1;
      default: r.ok = 1'b0;
    endcase
    if (e.parityKey == PAR_BAD) begin
      r.ok = 1'b0;
    end
    r.cfg.parity = e.parityKey;
    case (e.stopDigit)
      `STOP_KEY_1: r.cfg.twoStop = 1'b0;
      `STOP_KEY_2: r.cfg.twoStop = 1'b1;
      default: r.ok = 1'b0;
    endcase
    r.cfg.flowCtl = e.flow_control_select;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Settings accepted on the confirm key.
  always_comb begin
    chk[0] = checkEntry(entry[0]);
    chk[1] = checkEntry(entry[1]);
    allOk = chk[0].ok && chk[1].ok;
    next_activeCfg = activeCfg;
    next_inputRejected = inputRejected;
    if (confirm_key) begin
      // apply only a fully plausible set
      if (allOk) begin
        next_activeCfg[0] = chk[0].cfg;
        next_activeCfg[1] = chk[1].cfg;
        next_inputRejected = 1'b0;
      end else begin
        next_inputRejected = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      activeCfg <= {ResetCfg, ResetCfg};
      inputRejected <= 1'b0;
    end else begin
      activeCfg <= next_activeCfg;
      inputRejected <= next_inputRejected;
    end
  end

  assign effCfg[0] = activeCfg[0];
  assign effCfg[1] = syncFromString ? SyncCfg : activeCfg[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Channels.
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        ctsMeta[ch] <= 1'b0;
        ctsOk[ch] <= 1'b0;
      end else begin
        ctsMeta[ch] <= cts[ch];
        ctsOk[ch] <= ctsMeta[ch];
      end
    end

    serial_tx_channel #(
      .BitBase(`DIV_W'(BaseBitCycles))
    ) u_tx (
      .clk(ref_clk),
      .rst_n(rst_n),
      .cfg(effCfg[ch]),
      .ctsOk(ctsOk[ch]),
      .txData(txData[ch]),
      .txValid(txValid[ch]),
      .txReady(txReady[ch]),
      .txd(txd[ch]),
      .rts(rts[ch])
    );

    // Checks on the line and pacing of this channel.
    a_idle_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
      txReady[ch] |-> txd[ch])
      else $error("idle line not high");
    a_start_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (txValid[ch] && txReady[ch]) |=> !txd[ch] && !txReady[ch])
      else $error("taken character has no start bit");
    a_cts_sync: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($past(rst_n) && $past(rst_n, 2)) |-> ctsOk[ch] == $past(cts[ch], 2))
      else $error("clear to send not synchronised");
    a_rts_free: assert property (@(posedge ref_clk) disable iff (!rst_n)
      ($past(rst_n) && !$past(effCfg[ch].flowCtl)) |-> rts[ch])
      else $error("request to send low without handshake");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on configuration.
  a_reject_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (confirm_key && !allOk) |=> inputRejected && $stable(activeCfg))
    else $error("bad entry not rejected");
  a_accept_applies: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (confirm_key && allOk) |=> !inputRejected && activeCfg[1] == $past(chk[1].cfg)
    && activeCfg[0] == $past(chk[0].cfg)) else $error("good entry not applied");
  a_no_key_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !confirm_key |=> $stable(activeCfg) && $stable(inputRejected))
    else $error("settings changed without confirm");
  a_sync_forced: assert property (@(posedge ref_clk) disable iff (!rst_n)
    syncFromString |-> effCfg[1] == SyncCfg && effCfg[0] == activeCfg[0])
    else $error("sync did not force channel one");
  c_rejected: cover property (@(posedge ref_clk) disable iff (!rst_n)
    confirm_key && !allOk);
  c_both_busy: cover property (@(posedge ref_clk) disable iff (!rst_n)
    !txReady[0] && !txReady[1]);
endmodule

//--- host_serial_rx.sv
// Host serial port model: decodes one transmit line and paces it through CTS.
// Assumes the bench sets the expected framing before each start bit.
module host_serial_rx
  import serial_port_pkg::*;
#(
  parameter int Base = 4
) (
  // Clock
  input wire logic clk,
  // Line and pacing
  input wire logic rxd,
  input wire logic stall,
  output logic cts,
  // Expected framing
  input serial_port_pkg::chan_cfg_t cfg,
  // Result
  output logic [7:0] rxChar,
  output logic rxErr,
  output int rxCount
);
  int p;
  int nd;
  logic par;
  logic two;
  parity_t pk;

  assign cts = !stall;

  initial begin
    rxCount = 0;
    rxErr = 1'b0;
    rxChar = 8'h00;
    forever begin
      @(negedge rxd);
      p = Base << cfg.rateSel;
      nd = cfg.sevenBit ? 7 : 8;
      pk = cfg.parity;
      two = cfg.twoStop;
      repeat (p / 2) @(posedge clk);
      if (rxd !== 1'b0) rxErr = 1'b1;
      rxChar = 8'h00;
      par = pk == PAR_ODD;
      for (int i = 0; i < nd; i++) begin
        repeat (p) @(posedge clk);
        rxChar[i] = rxd;
        par = par ^ rxd;
      end
      if (pk != PAR_NONE) begin
        repeat (p) @(posedge clk);
        if ((par ^ rxd) !== 1'b0) rxErr = 1'b1;
      end
      for (int i = 0; i < (two ? 2 : 1); i++) begin
        repeat (p) @(posedge clk);
        if (rxd !== 1'b1) rxErr = 1'b1;
      end
      rxCount++;
    end
  end
endmodule

//--- configurable_dual_serial_port_tb.sv
// Self-checking bench for the dual serial port: settings, rates, framing, pacing.
// Assumes the package, the design and host_serial_rx are compiled before it.
`include "serial_port_consts.svh"
module configurable_dual_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import serial_port_pkg::*;

  localparam chan_cfg_t Dflt = '{`RESET_RATE_SEL, 1'b0, PAR_NONE, 1'b0, 1'b0};
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  entry_t [1:0] entry;
  logic confirm_key = 1'b0;
  logic syncFromString = 1'b0;
  logic [1:0][7:0] txData = 16'h0000;
  logic [1:0] txValid = 2'h0;
  logic [1:0] stall = 2'h0;
  logic [1:0] txReady;
  logic [1:0] txd;
  logic [1:0] rts;
  logic [1:0] cts;
  logic inputRejected;
  chan_cfg_t [1:0] activeCfg;
  chan_cfg_t [1:0] acc;
  chan_cfg_t [1:0] want;
  logic [1:0][7:0] rxChar;
  logic [1:0] rxErr;
  int rxCount [2];
  int fails = 0;
  int nTests = 0;
  logic [19:0] codes [8] = '{`RATE_CODE_19200, `RATE_CODE_9600, `RATE_CODE_4800,
    `RATE_CODE_2400, `RATE_CODE_1200, `RATE_CODE_600, `RATE_CODE_300, `RATE_CODE_150};

  configurable_dual_serial_port #(.BaseBitCycles(4)) i_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .entry(entry), .confirm_key(confirm_key),
    .syncFromString(syncFromString), .txData(txData), .txValid(txValid),
    .txReady(txReady), .txd(txd), .rts(rts), .cts(cts), .inputRejected(inputRejected),
    .activeCfg(activeCfg)
  );

  for (genvar c = 0; c < 2; c++) begin : g_host
    host_serial_rx #(.Base(4)) i_host (
      .clk(ref_clk), .rxd(txd[c]), .stall(stall[c]), .cts(cts[c]), .cfg(want[c]),
      .rxChar(rxChar[c]), .rxErr(rxErr[c]), .rxCount(rxCount[c])
    );
  end

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [31:0] e, logic [31:0] s);
    nTests++;
    if (e !== s) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask

  function automatic entry_t mk(chan_cfg_t f);
    return '{codes[f.rateSel], f.sevenBit ? 4'h7 : 4'h8, f.parity, f.twoStop ? 4'h2 : 4'h1,
      f.flowCtl};
  endfunction

  task automatic confirm(entry_t e0, entry_t e1);
    entry = {e1, e0};
    confirm_key = 1'b1;
    @(negedge ref_clk);
    confirm_key = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic chkSet(logic rej);
    chk("rejected", rej, inputRejected); // Flag level.
    chk("active cfg", acc, activeCfg); // Applied set.
  endtask

  task automatic apply(chan_cfg_t c0, chan_cfg_t c1);
    confirm(mk(c0), mk(c1));
    acc = {c1, c0};
    want = acc;
    chkSet(1'b0); // Both channels.
  endtask

  task automatic send(int c, logic [7:0] d);
    int k;
    int np;
    int n0;
    logic [7:0] m;
    np = (4 << want[c].rateSel) * (2 + (want[c].sevenBit ? 7 : 8)
      + (want[c].parity != PAR_NONE) + want[c].twoStop);
    m = want[c].sevenBit ? 8'h7f : 8'hff;
    n0 = rxCount[c];
    k = 0;
    txData[c] = d;
    txValid[c] = 1'b1;
    while (txReady[c] !== 1'b1 && k < 9000) begin
      @(negedge ref_clk);
      k++;
    end
    @(negedge ref_clk);
    txValid[c] = 1'b0;
    k = 1;
    while (txReady[c] !== 1'b1 && k < 9000) begin
      @(negedge ref_clk);
      k++;
    end
    chk("frame cycles", 1'b1, k >= np && k <= np + 2); // Frame length.
    chk("character", d & m, rxChar[c]); // Data bits.
    chk("line error", 1'b0, rxErr[c]); // Framing.
    chk("characters", n0 + 1, rxCount[c]); // One frame.
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chkSet(1'b0); // Reset set.
    chk("idle lines", 2'h3, txd); // Idle high.
    chk("free rts", 2'h3, rts); // No pacing.
  endtask

  task automatic t_rates();
    for (int r = 0; r < 8; r++) begin
      apply('{3'(r), 1'b0, PAR_NONE, 1'b0, 1'b0}, '{3'(7 - r), 1'b0, PAR_NONE, 1'b0, 1'b0});
      fork
        send(0, 8'ha5); // Every rate.
        send(1, 8'h3c); // Own divider.
      join
    end
  endtask

  task automatic t_frames();
    chan_cfg_t fr [4];
    fr = '{'{3'h0, 1'b1, PAR_EVEN, 1'b1, 1'b0}, '{3'h0, 1'b0, PAR_ODD, 1'b0, 1'b0},
      '{3'h0, 1'b1, PAR_ODD, 1'b0, 1'b0}, '{3'h0, 1'b0, PAR_EVEN, 1'b1, 1'b0}};
    for (int i = 0; i < 4; i++) begin
      apply(Dflt, fr[i]); // Parity modes.
      send(1, 8'hd3); // Stop counts.
    end
  endtask

  task automatic t_reject();
    entry_t e0;
    entry_t e1;
    for (int i = 0; i < 4; i++) begin
      e0 = mk(acc[0]);
      e1 = mk(acc[1]);
      case (i)
        0: e0.rateDigits = 20'h12345;
        1: e0.widthDigit = 4'h9;
        2: e1.parityKey = PAR_BAD;
        default: e1.stopDigit = 4'h3;
      endcase
      confirm(e0, e1);
      chkSet(1'b1); // Old set kept.
    end
    apply(acc[0], acc[1]); // Cleared again.
  endtask

  task automatic t_midchange();
    apply('{3'h2, 1'b0, PAR_NONE, 1'b0, 1'b0}, acc[1]);
    fork
      send(0, 8'h5a); // Frame kept.
      begin
        repeat (20) @(negedge ref_clk);
        apply('{3'h0, 1'b1, PAR_EVEN, 1'b1, 1'b0}, acc[1]); // Taken mid-frame.
      end
    join
    send(0, 8'h5a); // New framing.
  endtask

  task automatic t_handshake();
    apply('{3'h0, 1'b0, PAR_NONE, 1'b0, 1'b1}, acc[1]);
    stall[0] = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("rts idle", 2'h2, rts); // No request.
    txData[0] = 8'h81;
    txValid[0] = 1'b1;
    repeat (30) @(negedge ref_clk);
    chk("held ready", 1'b0, txReady[0]); // Held off.
    chk("held line", 1'b1, txd[0]); // Nothing sent.
    chk("rts wanted", 2'h3, rts); // Request shown.
    stall[0] = 1'b0;
    send(0, 8'h81); // Sent on release.
  endtask

  task automatic t_sync();
    apply(acc[0], '{3'h0, 1'b1, PAR_ODD, 1'b1, 1'b1});
    syncFromString = 1'b1;
    want[1] = '{`SYNC_RATE_SEL, 1'b0, PAR_NONE, 1'b0, 1'b0};
    repeat (3) @(negedge ref_clk);
    chk("sync rts", 1'b1, rts[1]); // Pacing off.
    send(1, 8'he7); // Forced framing.
    syncFromString = 1'b0;
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    entry = {mk(Dflt), mk(Dflt)};
    acc = {Dflt, Dflt};
    want = acc;
    repeat (20) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    t_reset();
    t_rates();
    t_frames();
    t_reject();
    t_midchange();
    t_handshake();
    t_sync();
    end_sim();
  end

  // Work above needs about 20000 cycles; this cuts a hang short.
  initial begin
    #1000000;
    fails++;
    end_sim();
  end
endmodule
